/* shared/rtcv_consts.svh */
// register offsets, field positions, masks and bcd limits of the rtc value block
`ifndef RTCV_CONSTS_SVH
`define RTCV_CONSTS_SVH
`define RTCV_CFG_OFS 8'h00
`define RTCV_TWIN_OFS 8'h04
`define RTCV_AWIN_OFS 8'h08
`define RTCV_WREN_BIT 0
`define RTCV_HALF_BIT 1
`define RTCV_TPTR_LO 4
`define RTCV_APTR_LO 6
`define RTCV_PTR_TIME_MINUTES_SECONDS 2'h0
`define RTCV_PTR_WKHR 2'h1
`define RTCV_PTR_TIME_MONTH_DAY 2'h2
`define RTCV_PTR_YEAR 2'h3
`define RTCV_MD_MASK 16'h1F3F
`define RTCV_WH_MASK 16'h073F
`define RTCV_MS_MASK 16'h7F7F
`define RTCV_MON_HI 12
`define RTCV_MON_LO 8
`define RTCV_DAY_HI 5
`define RTCV_WEEKDAY_VALUE_HI 10
`define RTCV_WEEKDAY_VALUE_LO 8
`define RTCV_HOUR_HI 5
`define RTCV_MIN_HI 14
`define RTCV_MIN_LO 8
`define RTCV_SEC_HI 6
`define RTCV_NINE 4'h9
`define RTCV_ZERO 8'h00
`define RTCV_ONE 8'h01
`define RTCV_SEC_LAST 8'h59
`define RTCV_HOUR_LAST 8'h23
`define RTCV_WEEKDAY_VALUE_LAST 8'h06
`define RTCV_MON_LAST 8'h12
`define RTCV_FEB 8'h02
`define RTCV_APR 8'h04
`define RTCV_JUN 8'h06
`define RTCV_SEP 8'h09
`define RTCV_NOV 8'h11
`define RTCV_DAYS28 8'h28
`define RTCV_DAYS29 8'h29
`define RTCV_DAYS30 8'h30
`define RTCV_DAYS31 8'h31
`endif

/* shared/rtcv_pkg.sv */
// types shared by the rtc value block
package rtcv_pkg;
    typedef logic [1:0] rtcv_ptr_t;
    typedef logic [15:0] rtcv_word_t;
    typedef logic [7:0] rtcv_bcd_t;
endpackage

/* logic/rtcv_values.sv */
// rtc time and alarm bcd value registers behind an apb window
`timescale 1ns/100ps
`default_nettype none
`include "rtcv_consts.svh"
module rtcv_values #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // apb slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timebase from the clock prescaler
    input wire logic secTick,
    input wire logic halfTick,
    input wire logic leapYear,
    // values for alarm compare and year logic
    output rtcv_pkg::rtcv_word_t timeMonthDay,
    output rtcv_pkg::rtcv_word_t timeWeekdayHours,
    output rtcv_pkg::rtcv_word_t timeMinutesSeconds,
    output rtcv_pkg::rtcv_word_t alarmMonthDay,
    output rtcv_pkg::rtcv_word_t alarmWeekdayHours,
    output rtcv_pkg::rtcv_word_t alarmMinutesSeconds,
    // control and status
    output logic valueWriteEnable,
    output logic halfSecondStatus,
    output rtcv_pkg::rtcv_ptr_t valueWindowPointer,
    output rtcv_pkg::rtcv_ptr_t alarmWindowPointer,
    output logic secondCarry
);

    // bcd step: wraps from last to first, else counts one digit pair up
    function automatic logic [8:0] bcdStep(input rtcv_pkg::rtcv_bcd_t v,
                                           input rtcv_pkg::rtcv_bcd_t last,
                                           input rtcv_pkg::rtcv_bcd_t first);
        if (v == last) begin
            return {1'b1, first};
        end else if (v[3:0] == `RTCV_NINE) begin
            return {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            return {1'b0, v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // last day of a bcd month
    function automatic rtcv_pkg::rtcv_bcd_t lastDay(input rtcv_pkg::rtcv_bcd_t mon,
                                                     input logic leap);
        if (mon == `RTCV_FEB) begin
            return leap ? `RTCV_DAYS29 : `RTCV_DAYS28;
        end else if (mon == `RTCV_APR || mon == `RTCV_JUN ||
                     mon == `RTCV_SEP || mon == `RTCV_NOV) begin
            return `RTCV_DAYS30;
        end else begin
            return `RTCV_DAYS31;
        end
    endfunction

    // window word selected by a pointer, unused bits forced low
    function automatic rtcv_pkg::rtcv_word_t selWord(input rtcv_pkg::rtcv_ptr_t ptr,
                                                      input rtcv_pkg::rtcv_word_t md,
                                                      input rtcv_pkg::rtcv_word_t wh,
                                                      input rtcv_pkg::rtcv_word_t ms);
        unique case (ptr)
            `RTCV_PTR_TIME_MONTH_DAY: return md & `RTCV_MD_MASK;
            `RTCV_PTR_WKHR: return wh & `RTCV_WH_MASK;
            `RTCV_PTR_TIME_MINUTES_SECONDS: return ms & `RTCV_MS_MASK;
            `RTCV_PTR_YEAR: return 16'h0000;
        endcase
    endfunction

    // byte-lane merge of a write, unused bits stored low
    function automatic rtcv_pkg::rtcv_word_t mergeBytes(input rtcv_pkg::rtcv_word_t old,
                                                         input logic [15:0] wd,
                                                         input logic [1:0] strb,
                                                         input rtcv_pkg::rtcv_word_t mask);
        return {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]} & mask;
    endfunction

    logic wenQ;
    logic halfQ;
    rtcv_pkg::rtcv_ptr_t tPtrQ;
    rtcv_pkg::rtcv_ptr_t aPtrQ;
    logic [31:0] rdataQ;
    rtcv_pkg::rtcv_word_t tMdQ, tWhQ, tMsQ, tMdD, tWhD, tMsD;
    rtcv_pkg::rtcv_word_t aMdQ, aWhQ, aMsQ;
    logic setup, access, cfgHit, tHit, aHit, mapped;
    logic tWrite, aWrite, tHigh, aHigh, halfClear;
    logic [8:0] sStep, mStep, hStep, wStep, dStep, moStep;

    // apb decode; zero wait states, error on unmapped address
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign cfgHit = paddr == ADDR_W'(`RTCV_CFG_OFS);
    assign tHit = paddr == ADDR_W'(`RTCV_TWIN_OFS);
    assign aHit = paddr == ADDR_W'(`RTCV_AWIN_OFS);
    assign mapped = cfgHit | tHit | aHit;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = rdataQ;

    // accepted window writes
    assign tWrite = access & pwrite & tHit & wenQ;
    assign aWrite = access & pwrite & aHit & (wenQ | aPtrQ == `RTCV_PTR_TIME_MINUTES_SECONDS);
    assign tHigh = access & tHit & (~pwrite | pstrb[1]);
    assign aHigh = access & aHit & (~pwrite | pstrb[1]);
    assign halfClear = access & pwrite & tHit & pstrb[0] & tPtrQ == `RTCV_PTR_TIME_MINUTES_SECONDS;

    // read data captured in the setup cycle
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rdataQ <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            if (cfgHit) begin
                rdataQ <= 32'({aPtrQ, tPtrQ, 2'b00, halfQ, wenQ});
            end else if (tHit) begin
                rdataQ <= {16'h0000, selWord(tPtrQ, tMdQ, tWhQ, tMsQ)};
            end else if (aHit) begin
                rdataQ <= {16'h0000, selWord(aPtrQ, aMdQ, aWhQ, aMsQ)};
            end else begin
                rdataQ <= 32'h0000_0000;
            end
        end
    end

    // write enable bit
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wenQ <= 1'b0;
        end else if (access && pwrite && cfgHit && pstrb[0]) begin
            wenQ <= pwdata[`RTCV_WREN_BIT];
        end
    end

    // window pointers: loaded by config write, count down on high access
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tPtrQ <= `RTCV_PTR_TIME_MINUTES_SECONDS;
            aPtrQ <= `RTCV_PTR_TIME_MINUTES_SECONDS;
        end else begin
            if (access && pwrite && cfgHit && pstrb[0]) begin
                tPtrQ <= pwdata[`RTCV_TPTR_LO +: 2];
                aPtrQ <= pwdata[`RTCV_APTR_LO +: 2];
            end
            if (tHigh && tPtrQ != `RTCV_PTR_TIME_MINUTES_SECONDS) begin
                tPtrQ <= tPtrQ - 2'h1;
            end
            if (aHigh && aPtrQ != `RTCV_PTR_TIME_MINUTES_SECONDS) begin
                aPtrQ <= aPtrQ - 2'h1;
            end
        end
    end

    // half-second status: set in second half, cleared at second or low write
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            halfQ <= 1'b0;
        end else if (halfTick) begin
            halfQ <= 1'b1;
        end else if (secTick || halfClear) begin
            halfQ <= 1'b0;
        end
    end

    // calendar carry chain
    always_comb begin
        sStep = bcdStep({1'b0, tMsQ[`RTCV_SEC_HI:0]}, `RTCV_SEC_LAST, `RTCV_ZERO);
        mStep = bcdStep({1'b0, tMsQ[`RTCV_MIN_HI:`RTCV_MIN_LO]},
                        `RTCV_SEC_LAST, `RTCV_ZERO);
        hStep = bcdStep({2'b00, tWhQ[`RTCV_HOUR_HI:0]}, `RTCV_HOUR_LAST, `RTCV_ZERO);
        wStep = bcdStep({5'b00000, tWhQ[`RTCV_WEEKDAY_VALUE_HI:`RTCV_WEEKDAY_VALUE_LO]},
                        `RTCV_WEEKDAY_VALUE_LAST, `RTCV_ZERO);
        dStep = bcdStep({2'b00, tMdQ[`RTCV_DAY_HI:0]},
                        lastDay({3'b000, tMdQ[`RTCV_MON_HI:`RTCV_MON_LO]}, leapYear),
                        `RTCV_ONE);
        moStep = bcdStep({3'b000, tMdQ[`RTCV_MON_HI:`RTCV_MON_LO]},
                         `RTCV_MON_LAST, `RTCV_ONE);
        tMsD = tMsQ;
        tWhD = tWhQ;
        tMdD = tMdQ;
        if (secTick) begin
            tMsD = {1'b0, mStep[6:0], 1'b0, sStep[6:0]};
            if (!sStep[8]) begin
                tMsD[`RTCV_MIN_HI:`RTCV_MIN_LO] = tMsQ[`RTCV_MIN_HI:`RTCV_MIN_LO];
            end
            if (sStep[8] && mStep[8]) begin
                tWhD = {5'b00000, tWhQ[`RTCV_WEEKDAY_VALUE_HI:`RTCV_WEEKDAY_VALUE_LO], 2'b00, hStep[5:0]};
                if (hStep[8]) begin
                    tWhD[`RTCV_WEEKDAY_VALUE_HI:`RTCV_WEEKDAY_VALUE_LO] = wStep[2:0];
                    tMdD = {3'b000, tMdQ[`RTCV_MON_HI:`RTCV_MON_LO], 2'b00, dStep[5:0]};
                    if (dStep[8]) begin
                        tMdD[`RTCV_MON_HI:`RTCV_MON_LO] = moStep[4:0];
                    end
                end
            end
        end
        // software write overlays the advanced value, no range check
        if (tWrite) begin
            unique case (tPtrQ)
                `RTCV_PTR_TIME_MONTH_DAY: tMdD = mergeBytes(tMdD, pwdata[15:0], pstrb[1:0],
                                                   `RTCV_MD_MASK);
                `RTCV_PTR_WKHR: tWhD = mergeBytes(tWhD, pwdata[15:0], pstrb[1:0],
                                                  `RTCV_WH_MASK);
                `RTCV_PTR_TIME_MINUTES_SECONDS: tMsD = mergeBytes(tMsD, pwdata[15:0], pstrb[1:0],
                                                    `RTCV_MS_MASK);
                `RTCV_PTR_YEAR: tMsD = tMsD;
            endcase
        end
    end

    // time values hold no reset value
    always_ff @(posedge clk_sys) begin
        tMdQ <= tMdD;
        tWhQ <= tWhD;
        tMsQ <= tMsD;
    end

    // alarm values change only on software writes
    always_ff @(posedge clk_sys) begin
        if (aWrite) begin
            unique case (aPtrQ)
                `RTCV_PTR_TIME_MONTH_DAY: aMdQ <= mergeBytes(aMdQ, pwdata[15:0], pstrb[1:0],
                                                    `RTCV_MD_MASK);
                `RTCV_PTR_WKHR: aWhQ <= mergeBytes(aWhQ, pwdata[15:0], pstrb[1:0],
                                                   `RTCV_WH_MASK);
                `RTCV_PTR_TIME_MINUTES_SECONDS: aMsQ <= mergeBytes(aMsQ, pwdata[15:0], pstrb[1:0],
                                                     `RTCV_MS_MASK);
                `RTCV_PTR_YEAR: aMsQ <= aMsQ;
            endcase
        end
    end

    // outputs
    assign timeMonthDay = tMdQ;
    assign timeWeekdayHours = tWhQ;
    assign timeMinutesSeconds = tMsQ;
    assign alarmMonthDay = aMdQ;
    assign alarmWeekdayHours = aWhQ;
    assign alarmMinutesSeconds = aMsQ;
    assign valueWriteEnable = wenQ;
    assign halfSecondStatus = halfQ;
    assign valueWindowPointer = tPtrQ;
    assign alarmWindowPointer = aPtrQ;
    assign secondCarry = secTick & sStep[8];

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_lockTime;
        access && pwrite && tHit && !wenQ && !secTick |=>
            tMdQ == $past(tMdQ) && tWhQ == $past(tWhQ) && tMsQ == $past(tMsQ);
    endproperty
    a_lockTime: assert property (p_lockTime) else $error("locked time write took");

    property p_lockAlarm;
        access && pwrite && aHit && !wenQ && aPtrQ == `RTCV_PTR_WKHR |=>
            aWhQ == $past(aWhQ);
    endproperty
    a_lockAlarm: assert property (p_lockAlarm) else $error("locked alarm write took");

    property p_mdRead;
        setup && !pwrite && tHit && tPtrQ == `RTCV_PTR_TIME_MONTH_DAY |=>
            (prdata & ~32'h0000_1F3F) == 32'h0000_0000;
    endproperty
    a_mdRead: assert property (p_mdRead) else $error("unused month-day bit set");

    property p_ptrDown;
        tHigh && tPtrQ != 2'h0 |=> tPtrQ == $past(tPtrQ) - 2'h1;
    endproperty
    a_ptrDown: assert property (p_ptrDown) else $error("pointer did not count down");

    property p_ptrFloor;
        tHigh && tPtrQ == 2'h0 && !(pwrite && cfgHit) |=> tPtrQ == 2'h0;
    endproperty
    a_ptrFloor: assert property (p_ptrFloor) else $error("pointer left zero");

    property p_halfClear;
        halfClear && !halfTick ##1 !halfTick[*2] |-> !halfQ;
    endproperty
    a_halfClear: assert property (p_halfClear) else $error("half status not cleared");

    property p_secOnes;
        secTick && !tWrite && tMsQ[6:0] == 7'h12 |=> tMsQ[6:0] == 7'h13;
    endproperty
    a_secOnes: assert property (p_secOnes) else $error("seconds ones wrong");

    property p_minuteCarry;
        secTick && !tWrite && tMsQ == 16'h0959 |=> tMsQ == 16'h1000;
    endproperty
    a_minuteCarry: assert property (p_minuteCarry) else $error("minute carry wrong");

    property p_midnight;
        secTick && !tWrite && tMsQ == 16'h5959 && tWhQ == 16'h0623 |=> tWhQ == 16'h0000;
    endproperty
    a_midnight: assert property (p_midnight) else $error("hour or weekday wrap wrong");

    property p_febEnd;
        secTick && !tWrite && !leapYear && tMsQ == 16'h5959 && tWhQ[5:0] == 6'h23 &&
            tMdQ == 16'h0228 |=> tMdQ == 16'h0301;
    endproperty
    a_febEnd: assert property (p_febEnd) else $error("february end wrong");

    property p_yearEnd;
        secTick && !tWrite && tMsQ == 16'h5959 && tWhQ[5:0] == 6'h23 &&
            tMdQ == 16'h1231 |=> tMdQ == 16'h0101 ##1 tMdQ == 16'h0101;
    endproperty
    a_yearEnd: assert property (p_yearEnd) else $error("month wrap wrong");

    property p_alarmWrite;
        aWrite && aPtrQ == 2'h1 && pstrb[1:0] == 2'b11 |=>
            aWhQ == ($past(pwdata[15:0]) & 16'h073F);
    endproperty
    a_alarmWrite: assert property (p_alarmWrite) else $error("alarm write lost");

    c_timeWrite: cover property (tWrite ##1 tHigh);
    c_dayRoll: cover property (secTick && sStep[8] && mStep[8] && hStep[8]);
    c_lockedWrite: cover property (access && pwrite && tHit && !wenQ);
    c_halfClear: cover property (halfQ ##1 halfClear);

endmodule
`default_nettype wire

/* test/rtcv_values_tb.sv */
// self-checking bench for the rtc time and alarm value registers
`timescale 1ns/100ps
`default_nettype none
`include "rtcv_consts.svh"
module tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic secTick = 1'b0;
    logic halfTick = 1'b0;
    logic leapYear = 1'b0;
    rtcv_pkg::rtcv_word_t timeMonthDay, timeWeekdayHours, timeMinutesSeconds;
    rtcv_pkg::rtcv_word_t alarmMonthDay, alarmWeekdayHours, alarmMinutesSeconds;
    logic valueWriteEnable, halfSecondStatus, secondCarry;
    rtcv_pkg::rtcv_ptr_t valueWindowPointer, alarmWindowPointer;
    int errors = 0;
    int nTests = 0;
    logic [31:0] rd;
    logic err;

    rtcv_values #(.ADDR_W(8)) DUT (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .secTick(secTick),
        .halfTick(halfTick), .leapYear(leapYear), .timeMonthDay(timeMonthDay),
        .timeWeekdayHours(timeWeekdayHours), .timeMinutesSeconds(timeMinutesSeconds),
        .alarmMonthDay(alarmMonthDay), .alarmWeekdayHours(alarmWeekdayHours),
        .alarmMinutesSeconds(alarmMinutesSeconds), .valueWriteEnable(valueWriteEnable),
        .halfSecondStatus(halfSecondStatus), .valueWindowPointer(valueWindowPointer),
        .alarmWindowPointer(alarmWindowPointer), .secondCarry(secondCarry)
    );

    // 50 mhz clock
    always #10 clk_sys = ~clk_sys;

    // verdict and end of run
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // compare after the edge's updates have landed
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        nTests++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d,
                       input logic [3:0] s);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            errors++;
            $display("BAD %0t no pready", $time);
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    function automatic logic [31:0] cfgw(input logic wen, input logic [1:0] tp,
                                         input logic [1:0] ap);
        return 32'(wen) | (32'(tp) << `RTCV_TPTR_LO) | (32'(ap) << `RTCV_APTR_LO);
    endfunction

    // one second tick, carry seen while it is high
    task automatic tick(input logic expCarry);
        @(posedge clk_sys);
        secTick <= 1'b1;
        #1;
        chk(32'(secondCarry), 32'(expCarry), "carry");
        @(posedge clk_sys);
        secTick <= 1'b0;
        #1;
    endtask

    task automatic t_reset();
        apb(`RTCV_CFG_OFS, 1'b0, 32'h0, 4'hF);
        chk(rd, 32'h0, "config after reset");
        chk(32'(valueWindowPointer), 32'h0, "time pointer reset");
    endtask

    // load time and alarm, pointer walks down and stops, unused bits read 0
    task automatic t_load();
        apb(`RTCV_CFG_OFS, 1'b1, cfgw(1'b1, 2'h2, 2'h2), 4'hF);
        apb(`RTCV_TWIN_OFS, 1'b1, 32'h0000F2F1, 4'h3);
        chk(32'(timeMonthDay), 32'h1231, "month-day");
        chk(32'(valueWindowPointer), 32'h1, "pointer after month-day");
        apb(`RTCV_TWIN_OFS, 1'b1, 32'h0000FEE3, 4'h3);
        chk(32'(timeWeekdayHours), 32'h0623, "weekday-hours");
        apb(`RTCV_TWIN_OFS, 1'b1, 32'h0000D9D9, 4'h3);
        chk(32'(timeMinutesSeconds), 32'h5959, "min-sec");
        chk(32'(valueWindowPointer), 32'h0, "pointer stops at 00");
        apb(`RTCV_AWIN_OFS, 1'b1, 32'h00000115, 4'h3);
        apb(`RTCV_AWIN_OFS, 1'b1, 32'h00000307, 4'h3);
        apb(`RTCV_AWIN_OFS, 1'b1, 32'h00003045, 4'h3);
        chk(32'(alarmMonthDay), 32'h0115, "alarm month-day");
        chk(32'(alarmWeekdayHours), 32'h0307, "alarm weekday-hours");
        chk(32'(alarmMinutesSeconds), 32'h3045, "alarm min-sec");
        chk(32'(alarmWindowPointer), 32'h0, "alarm pointer stops at 00");
        apb(`RTCV_CFG_OFS, 1'b1, cfgw(1'b1, 2'h2, 2'h0), 4'hF);
        apb(`RTCV_TWIN_OFS, 1'b0, 32'h0, 4'h0);
        chk(rd, 32'h1231, "month-day read back");
        chk(32'(valueWindowPointer), 32'h1, "pointer after read");
    endtask

    // full rollover, alarm untouched by the timebase
    task automatic t_roll();
        tick(1'b1);
        chk(32'(timeMonthDay), 32'h0101, "year end month-day");
        chk(32'(timeWeekdayHours), 32'h0000, "weekday wraps from 6");
        chk(32'(timeMinutesSeconds), 32'h0000, "min-sec rollover");
        chk(32'(alarmMonthDay), 32'h0115, "alarm kept");
        tick(1'b0);
        chk(32'(timeMinutesSeconds), 32'h0001, "second advance");
    endtask

    // month-day and weekday-hours writes with the enable clear are dropped
    task automatic t_lock();
        apb(`RTCV_CFG_OFS, 1'b1, cfgw(1'b0, 2'h2, 2'h2), 4'hF);
        chk(32'(valueWriteEnable), 32'h0, "enable cleared");
        apb(`RTCV_TWIN_OFS, 1'b1, 32'h00000505, 4'h3);
        apb(`RTCV_AWIN_OFS, 1'b1, 32'h00000505, 4'h3);
        chk(32'(timeMonthDay), 32'h0101, "locked month-day");
        chk(32'(alarmMonthDay), 32'h0115, "locked alarm month-day");
        apb(`RTCV_TWIN_OFS, 1'b1, 32'h00000202, 4'h3);
        apb(`RTCV_AWIN_OFS, 1'b1, 32'h00000202, 4'h3);
        chk(32'(timeWeekdayHours), 32'h0000, "locked weekday-hours");
        chk(32'(alarmWeekdayHours), 32'h0307, "locked alarm weekday-hours");
    endtask

    // end of february with and without leap year
    task automatic t_leap();
        logic [15:0] exp [2];
        exp[0] = 16'h0301;
        exp[1] = 16'h0229;
        for (int i = 0; i < 2; i++) begin
            leapYear <= 1'(i);
            apb(`RTCV_CFG_OFS, 1'b1, cfgw(1'b1, 2'h2, 2'h0), 4'hF);
            apb(`RTCV_TWIN_OFS, 1'b1, 32'h00000228, 4'h3);
            apb(`RTCV_TWIN_OFS, 1'b1, 32'h00000023, 4'h3);
            apb(`RTCV_TWIN_OFS, 1'b1, 32'h00005959, 4'h3);
            tick(1'b1);
            chk(32'(timeMonthDay), 32'(exp[i]), "february end");
            chk(32'(timeWeekdayHours), 32'h0100, "weekday advance");
        end
    endtask

    // half status set, read-only, cleared by a low-byte write
    task automatic t_half();
        @(posedge clk_sys);
        halfTick <= 1'b1;
        @(posedge clk_sys);
        halfTick <= 1'b0;
        #1;
        chk(32'(halfSecondStatus), 32'h1, "half set");
        apb(`RTCV_CFG_OFS, 1'b1, cfgw(1'b1, 2'h0, 2'h0), 4'hF);
        apb(`RTCV_CFG_OFS, 1'b0, 32'h0, 4'h0);
        chk(rd, 32'h3, "half read-only in config");
        apb(`RTCV_TWIN_OFS, 1'b1, 32'h00003412, 4'h1);
        chk(32'(halfSecondStatus), 32'h0, "half cleared");
        chk(32'(timeMinutesSeconds), 32'h0012, "low byte only");
        tick(1'b0);
        chk(32'(timeMinutesSeconds), 32'h0013, "seconds ones step");
        apb(`RTCV_TWIN_OFS, 1'b1, 32'h00000959, 4'h3);
        tick(1'b1);
        chk(32'(timeMinutesSeconds), 32'h1000, "minute tens carry");
    endtask

    task automatic t_unmapped();
        apb(8'h0C, 1'b0, 32'h0, 4'h0);
        chk(rd, 32'h0, "unmapped read");
        chk(32'(err), 32'h1, "unmapped error");
        apb(`RTCV_AWIN_OFS, 1'b0, 32'h0, 4'h0);
        chk(32'(err), 32'h0, "mapped no error");
        chk(rd, 32'h3045, "alarm min-sec read");
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_load();
        t_roll();
        t_lock();
        t_leap();
        t_half();
        t_unmapped();
        finish_test();
    end
endmodule
`default_nettype wire
